// ===== rtl/tpc_pkg.sv
// Shared constants for the timer, PWM, pulse generator and capture block
package tpc_pkg;

	// =========================================================
	// Register bus widths
	// =========================================================
	localparam int unsigned TPC_AW = 4;  // Address width
	localparam int unsigned TPC_DW = 16; // Data width

	// =========================================================
	// Register offsets
	// =========================================================
	localparam logic [3:0] TPC_OFF_MODE = 4'h0; // mode_control_reg
	localparam logic [3:0] TPC_OFF_CLK  = 4'h1; // clock_select_reg
	localparam logic [3:0] TPC_OFF_OUTC = 4'h2; // output_control_reg
	localparam logic [3:0] TPC_OFF_EDGE = 4'h3; // edge_mode_reg
	localparam logic [3:0] TPC_OFF_SCS  = 4'h4; // sampling_clock_select
	localparam logic [3:0] TPC_OFF_CCA  = 4'h5; // compare_capture_a
	localparam logic [3:0] TPC_OFF_CCB  = 4'h6; // compare_capture_b
	localparam logic [3:0] TPC_OFF_CNT  = 4'h7; // timer_count, read only
	localparam logic [3:0] TPC_OFF_STAT = 4'h8; // Pin and input levels

	// =========================================================
	// Field positions
	// =========================================================
	localparam int unsigned TPC_MODE_LSB   = 0; // Mode, 3 bits
	localparam int unsigned TPC_CLKSEL_LSB = 4; // Count clock, bits 6:4
	localparam int unsigned TPC_OE_BIT     = 0; // output_enable_bit
	localparam int unsigned TPC_ALV_BIT    = 1; // active_level_select
	localparam int unsigned TPC_ESA_LSB    = 2; // edge_sel_a, bits 3:2
	localparam int unsigned TPC_ESB_LSB    = 4; // edge_sel_b, bits 5:4
	localparam int unsigned TPC_SCS_LSB    = 0; // Sampling select, 2 bits

	// =========================================================
	// Reset values
	// =========================================================
	localparam logic [15:0] TPC_RST_REG = 16'h0000; // All registers

	// =========================================================
	// Operating modes
	// =========================================================
	localparam logic [2:0] TPC_M_STOP    = 3'h0; // Counter held at zero
	localparam logic [2:0] TPC_M_PWM     = 3'h1; // 14-bit PWM
	localparam logic [2:0] TPC_M_PPG     = 3'h2; // programmable_pulse_mode
	localparam logic [2:0] TPC_M_CAP1    = 3'h3; // Free run, one capture
	localparam logic [2:0] TPC_M_CAP2IN  = 3'h4; // Free run, two inputs
	localparam logic [2:0] TPC_M_CAP2REG = 3'h5; // Free run, two registers
	localparam logic [2:0] TPC_M_RESTART = 3'h6; // Capture then restart
	localparam logic [2:0] TPC_M_EVENT   = 3'h7; // External event counter

	// =========================================================
	// Edge selections
	// =========================================================
	localparam logic [1:0] TPC_E_FALL = 2'h0; // Falling edge
	localparam logic [1:0] TPC_E_RISE = 2'h1; // Rising edge
	localparam logic [1:0] TPC_E_NONE = 2'h2; // No edge
	localparam logic [1:0] TPC_E_BOTH = 2'h3; // Both edges

	// =========================================================
	// Count clock and PWM structure
	// =========================================================
	localparam logic [2:0] TPC_CLK_EXT  = 3'h0; // Edges of trigger A
	localparam int unsigned TPC_PRE_W   = 8;    // Prescaler width
	localparam int unsigned TPC_PWM_BASE = 8;   // Basic cycle 2^8
	localparam int unsigned TPC_PWM_SUB  = 14;  // Sub-cycle 2^14

endpackage

// ===== rtl/tpc_timer.sv
// 16-bit timer with PWM, pulse generator, capture and event counting
//
// The implementer's own choices: the register addresses and the strobed register port.
module tpc_timer
	import tpc_pkg::*;
(
	input  wire logic              core_clk_in,          // Core clock
	input  wire logic              rst_in,               // Synchronous reset
	input  wire logic [TPC_AW-1:0] reg_addr_in,          // Register address
	input  wire logic [TPC_DW-1:0] reg_wdata_in,         // Write data
	input  wire logic              reg_wr_in,            // Write strobe
	input  wire logic              reg_rd_in,            // Read strobe
	output logic      [TPC_DW-1:0] reg_rdata_out,        // Read data
	input  wire logic              trigger_input_a_in,   // Trigger A pin
	input  wire logic              trigger_input_b_in,   // Trigger B pin
	output logic                   timer_output_pin_out, // Waveform pin
	output logic                   capture_a_irq_out,    // Capture A pulse
	output logic                   capture_b_irq_out,    // Capture B pulse
	output logic                   match_irq_out         // Match pulse
);

	// =========================================================
	// Functions
	// =========================================================

	// Strobe once per 2^n core clocks from the prescaler
	function automatic logic div_tick(input logic [TPC_PRE_W-1:0] cnt,
		input logic [2:0] n);
		logic [TPC_PRE_W-1:0] mask;
		mask = ~({TPC_PRE_W{1'b1}} << n);
		div_tick = ((cnt & mask) == mask);
	endfunction

	// Valid edge according to an edge selection
	function automatic logic edge_hit(input logic [1:0] sel,
		input logic rise, input logic fall);
		edge_hit = ((sel == TPC_E_RISE) || (sel == TPC_E_BOTH)) && rise
			|| ((sel == TPC_E_FALL) || (sel == TPC_E_BOTH)) && fall;
	endfunction

	// =========================================================
	// Software registers
	// =========================================================
	logic [2:0]  mode_q;  // Operating mode
	logic [2:0]  clks_q;  // Count clock select
	logic        oe_q;    // output_enable_bit
	logic        alv_q;   // active_level_select
	logic [1:0]  esa_q;   // edge_sel_a
	logic [1:0]  esb_q;   // edge_sel_b
	logic [1:0]  scs_q;   // sampling_clock_select
	logic [15:0] cca_q;   // compare_capture_a
	logic [15:0] cca_d;   // Next compare_capture_a
	logic [15:0] ccb_q;   // compare_capture_b
	logic [15:0] ccb_d;   // Next compare_capture_b
	logic [15:0] cnt_q;   // timer_count
	logic [15:0] cnt_d;   // Next timer_count
	logic [15:0] rdat_q;  // Read data register

	// Internal state
	logic [TPC_PRE_W-1:0] pre_q;  // Free prescaler
	logic                 pin_q;  // Output pin register
	logic                 pin_d;  // Next pin level
	logic                 irqa_q; // Capture A pulse
	logic                 irqb_q; // Capture B pulse
	logic                 irqm_q; // Match pulse

	// =========================================================
	// Register decode
	// =========================================================
	wire wr_mode_w = reg_wr_in && (reg_addr_in == TPC_OFF_MODE); // Mode write
	wire wr_clk_w  = reg_wr_in && (reg_addr_in == TPC_OFF_CLK);  // Clock write
	wire wr_outc_w = reg_wr_in && (reg_addr_in == TPC_OFF_OUTC); // Output write
	wire wr_edge_w = reg_wr_in && (reg_addr_in == TPC_OFF_EDGE); // Edge write
	wire wr_scs_w  = reg_wr_in && (reg_addr_in == TPC_OFF_SCS);  // Sampling write
	wire wr_cca_w  = reg_wr_in && (reg_addr_in == TPC_OFF_CCA);  // A write
	wire wr_ccb_w  = reg_wr_in && (reg_addr_in == TPC_OFF_CCB);  // B write

	// =========================================================
	// Sampling strobe and trigger filters
	// =========================================================
	wire       smp_w;   // Sampling strobe
	wire       lvla_w;  // Filtered level A
	wire       lvlb_w;  // Filtered level B
	wire       risea_w; // Rising edge A
	wire       falla_w; // Falling edge A
	wire       riseb_w; // Rising edge B
	wire       fallb_w; // Falling edge B

	// Sampling period set by sampling_clock_select
	assign smp_w = div_tick(pre_q, {1'b0, scs_q});

	// Filter for trigger A
	tpc_trig_filter u_filt_a (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.sig_in      (trigger_input_a_in),
		.sample_in   (smp_w),
		.level_out   (lvla_w),
		.rise_out    (risea_w),
		.fall_out    (falla_w)
	);

	// Filter for trigger B
	tpc_trig_filter u_filt_b (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.sig_in      (trigger_input_b_in),
		.sample_in   (smp_w),
		.level_out   (lvlb_w),
		.rise_out    (riseb_w),
		.fall_out    (fallb_w)
	);

	// =========================================================
	// Edge events
	// =========================================================
	wire evta_w; // Valid edge on A
	wire evtb_w; // Valid edge on B
	wire oppa_w; // Opposite edge on A
	wire tick_w; // Count clock strobe

	assign evta_w = edge_hit(esa_q, risea_w, falla_w);
	assign evtb_w = edge_hit(esb_q, riseb_w, fallb_w);

	// Reverse edge of a single-edge selection; none for both
	assign oppa_w = (esa_q == TPC_E_RISE) ? falla_w
		: (esa_q == TPC_E_FALL) ? risea_w : 1'b0;

	// Count clock: external edges or divided core clock
	assign tick_w = (clks_q == TPC_CLK_EXT) ? evta_w
		: div_tick(pre_q, 3'(clks_q - 3'h1));

	// =========================================================
	// Mode qualifiers
	// =========================================================
	wire m_cap_w;   // Any capture mode
	wire capb_w;    // Capture count into B
	wire capa2_w;   // Capture count into A
	wire match_w;   // Count equals A on a tick
	wire evmode_w;  // Event counter mode

	assign m_cap_w = (mode_q == TPC_M_CAP1) || (mode_q == TPC_M_CAP2IN)
		|| (mode_q == TPC_M_CAP2REG) || (mode_q == TPC_M_RESTART);
	assign capb_w  = m_cap_w && evta_w;
	assign capa2_w = ((mode_q == TPC_M_CAP2IN) && evtb_w)
		|| (((mode_q == TPC_M_CAP2REG) || (mode_q == TPC_M_RESTART))
		&& oppa_w);
	assign evmode_w = (mode_q == TPC_M_EVENT);
	assign match_w = (evmode_w ? evta_w : tick_w) && (cnt_q == cca_q)
		&& (evmode_w || (mode_q == TPC_M_PPG));

	// =========================================================
	// Counter next value
	// =========================================================
	always_comb
	begin
		cnt_d = cnt_q;
		case (mode_q)
			TPC_M_STOP:
				cnt_d = 16'h0000; // Held cleared
			TPC_M_EVENT:
				if (evta_w)
					cnt_d = match_w ? 16'h0000 : 16'(cnt_q + 16'h0001);
			TPC_M_PPG:
				if (tick_w)
					cnt_d = match_w ? 16'h0000 : 16'(cnt_q + 16'h0001);
			TPC_M_RESTART:
				if (capb_w)
					cnt_d = 16'h0000;
				else if (tick_w)
					cnt_d = 16'(cnt_q + 16'h0001);
			default:
				if (tick_w) // Free running
					cnt_d = 16'(cnt_q + 16'h0001);
		endcase
	end

	// =========================================================
	// Capture registers: hardware capture wins over a write
	// =========================================================
	assign ccb_d = capb_w ? cnt_q : (wr_ccb_w ? reg_wdata_in : ccb_q);
	assign cca_d = capa2_w ? cnt_q : (wr_cca_w ? reg_wdata_in : cca_q);

	// =========================================================
	// PWM waveform
	// =========================================================
	wire [13:0] duty_w;  // 14-bit duty
	wire [5:0]  sub_w;   // Sub-cycle index
	wire [5:0]  subr_w;  // Bit-reversed index
	wire        extra_w; // Extra count this basic cycle
	wire [8:0]  wid_w;   // Width of this basic cycle
	wire        pwm_w;   // PWM active

	assign duty_w = cca_q[15:2];
	assign sub_w  = cnt_q[TPC_PWM_SUB-1:TPC_PWM_BASE];

	// Reverse the index to spread extra counts evenly
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++)
		begin : g_rev
			assign subr_w[gi] = sub_w[5 - gi];
		end
	endgenerate

	assign extra_w = (subr_w < duty_w[5:0]);
	assign wid_w   = {1'b0, duty_w[13:6]} + {8'h00, extra_w};
	assign pwm_w   = ({1'b0, cnt_q[TPC_PWM_BASE-1:0]} < wid_w);

	// =========================================================
	// Output selection
	// =========================================================
	wire ppg_w; // Pulse mode active
	wire act_w; // Active in current mode

	assign ppg_w = (cnt_q <= ccb_q);
	assign act_w = (mode_q == TPC_M_PWM) ? pwm_w
		: (mode_q == TPC_M_PPG) ? ppg_w : 1'b0;

	// Enabled output inverted for active low
	assign pin_d = oe_q && (act_w ^ alv_q);

	// =========================================================
	// Read multiplexer
	// =========================================================
	logic [15:0] rmux_w; // Selected read value
	always_comb
	begin
		rmux_w = 16'h0000;
		case (reg_addr_in)
			TPC_OFF_MODE: rmux_w = {13'h0000, mode_q};
			TPC_OFF_CLK:  rmux_w = {9'h000, clks_q, 4'h0};
			TPC_OFF_OUTC: rmux_w = {14'h0000, alv_q, oe_q};
			TPC_OFF_EDGE: rmux_w = {10'h000, esb_q, esa_q, 2'h0};
			TPC_OFF_SCS:  rmux_w = {14'h0000, scs_q};
			TPC_OFF_CCA:  rmux_w = cca_q;
			TPC_OFF_CCB:  rmux_w = ccb_q;
			TPC_OFF_CNT:  rmux_w = cnt_q;
			TPC_OFF_STAT: rmux_w = {13'h0000, lvlb_w, lvla_w, pin_q};
			default:      rmux_w = 16'h0000; // Unmapped
		endcase
	end

	// =========================================================
	// Control registers
	// =========================================================
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			mode_q <= TPC_RST_REG[2:0];
			clks_q <= TPC_RST_REG[2:0];
			oe_q   <= TPC_RST_REG[0];
			alv_q  <= TPC_RST_REG[0];
			esa_q  <= TPC_RST_REG[1:0];
			esb_q  <= TPC_RST_REG[1:0];
			scs_q  <= TPC_RST_REG[1:0];
		end
		else
		begin
			if (wr_mode_w)
				mode_q <= reg_wdata_in[TPC_MODE_LSB +: 3];
			if (wr_clk_w)
				clks_q <= reg_wdata_in[TPC_CLKSEL_LSB +: 3];
			if (wr_outc_w)
			begin
				oe_q  <= reg_wdata_in[TPC_OE_BIT];
				alv_q <= reg_wdata_in[TPC_ALV_BIT];
			end
			if (wr_edge_w)
			begin
				esa_q <= reg_wdata_in[TPC_ESA_LSB +: 2];
				esb_q <= reg_wdata_in[TPC_ESB_LSB +: 2];
			end
			if (wr_scs_w)
				scs_q <= reg_wdata_in[TPC_SCS_LSB +: 2];
		end
	end

	// =========================================================
	// Counter, capture and output registers
	// =========================================================
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			pre_q  <= '0;
			cnt_q  <= TPC_RST_REG;
			cca_q  <= TPC_RST_REG;
			ccb_q  <= TPC_RST_REG;
			pin_q  <= 1'b0;
			irqa_q <= 1'b0;
			irqb_q <= 1'b0;
			irqm_q <= 1'b0;
		end
		else
		begin
			pre_q  <= pre_q + 1'b1;
			cnt_q  <= cnt_d;
			cca_q  <= cca_d;
			ccb_q  <= ccb_d;
			pin_q  <= pin_d;
			irqa_q <= capb_w;
			irqb_q <= (mode_q == TPC_M_CAP2IN) && evtb_w;
			irqm_q <= match_w;
		end
	end

	// Read data stands one cycle after the strobe
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			rdat_q <= TPC_RST_REG;
		else if (reg_rd_in)
			rdat_q <= rmux_w;
		else
			rdat_q <= 16'h0000;
	end

	// =========================================================
	// Outputs
	// =========================================================
	assign reg_rdata_out        = rdat_q;
	assign timer_output_pin_out = pin_q;
	assign capture_a_irq_out    = irqa_q;
	assign capture_b_irq_out    = irqb_q;
	assign match_irq_out        = irqm_q;

endmodule // tpc_timer

// ===== rtl/tpc_trig_filter.sv
// Sampled noise filter and edge detector for one trigger input
module tpc_trig_filter
	import tpc_pkg::*;
(
	input  wire logic core_clk_in,  // Core clock
	input  wire logic rst_in,       // Synchronous reset
	input  wire logic sig_in,       // Raw trigger level
	input  wire logic sample_in,    // Sampling strobe
	output logic      level_out,    // Filtered level
	output logic      rise_out,     // One-cycle rising pulse
	output logic      fall_out      // One-cycle falling pulse
);

	// =========================================================
	// Sample history
	// =========================================================
	logic smp_q;   // Previous sample
	logic lvl_q;   // Accepted level
	logic rise_q;  // Rising pulse
	logic fall_q;  // Falling pulse
	wire  accept_w; // New level seen on two samples

	// Two equal samples that differ from the accepted level
	assign accept_w = sample_in && (sig_in == smp_q) && (sig_in != lvl_q);

	// Sample and accept levels
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			smp_q  <= 1'b0;
			lvl_q  <= 1'b0;
			rise_q <= 1'b0;
			fall_q <= 1'b0;
		end
		else
		begin
			if (sample_in)
				smp_q <= sig_in;
			if (accept_w)
				lvl_q <= sig_in;
			rise_q <= accept_w && sig_in;
			fall_q <= accept_w && !sig_in;
		end
	end

	assign level_out = lvl_q;
	assign rise_out  = rise_q;
	assign fall_out  = fall_q;

endmodule // tpc_trig_filter

// ===== tb/timer_pwm_ppg_capture_modes_test.sv
// Self-checking testbench for the timer block
`define CHK(g, e) \
	begin \
		total_checks++; \
		if ((g) !== (e)) \
		begin \
			error_cnt++; \
			$display("FAIL %0t got %0h exp %0h", $time, (g), (e)); \
		end \
	end
module timer_pwm_ppg_capture_modes_test
	import tpc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	// =========================================
	// Signals
	// =========================================
	logic        core_clk_in  = 1'b0;
	logic        rst_in       = 1'b1;
	logic [3:0]  reg_addr_in  = 4'h0;
	logic [15:0] reg_wdata_in = 16'h0000;
	logic        reg_wr_in    = 1'b0;
	logic        reg_rd_in    = 1'b0;
	logic [15:0] reg_rdata_out, va, vb, vd;
	logic        trig_a, trig_b, pin, irq_ca, irq_cb, irq_m;
	logic [31:0] seed = 32'h0000_3967; // Fixed seed
	int error_cnt = 0, total_checks = 0, n_ca = 0, n_cb = 0, n_m = 0, i, k, per, hi;
	logic [15:0] msk [7] = '{16'h0007, 16'h0070, 16'h0003, 16'h003C, 16'h0003,
		16'hFFFF, 16'hFFFF}; // Writable bits per register
	logic [1:0]  ecode [4] = '{TPC_E_FALL, TPC_E_RISE, TPC_E_BOTH, TPC_E_NONE};
	int          nexp [4] = '{2, 2, 4, 0}; // Captures for two pulses

	tpc_pulse_src i_src (.core_clk_in(core_clk_in), .trig_a_out(trig_a), .trig_b_out(trig_b));
	tpc_timer i_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .trigger_input_a_in(trig_a),
		.trigger_input_b_in(trig_b), .timer_output_pin_out(pin),
		.capture_a_irq_out(irq_ca), .capture_b_irq_out(irq_cb), .match_irq_out(irq_m));

	always #2.5 core_clk_in = ~core_clk_in;
	// Count irq pulses
	always @(posedge core_clk_in)
	begin
		n_ca += irq_ca === 1'b1;
		n_cb += irq_cb === 1'b1;
		n_m  += irq_m === 1'b1;
	end
	// =========================================
	// Helpers
	// =========================================
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge core_clk_in);
		reg_addr_in  <= a;
		reg_wdata_in <= v;
		reg_wr_in    <= 1'b1;
		@(posedge core_clk_in);
		reg_wr_in    <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge core_clk_in);
		reg_addr_in <= a;
		reg_rd_in   <= 1'b1;
		@(posedge core_clk_in);
		reg_rd_in   <= 1'b0;
		#1 v = reg_rdata_out;
	endtask
	// Stop first so the count restarts from zero, then set clock, edges {b,a},
	// sampling, output control and finally the mode
	task automatic cfg(input logic [2:0] m, input logic [2:0] c, input logic [3:0] e,
		input logic [1:0] s, input logic [1:0] o);
		wr(TPC_OFF_MODE, 16'h0000);
		wr(TPC_OFF_CLK, {9'h000, c, 4'h0});
		wr(TPC_OFF_EDGE, {10'h000, e, 2'h0});
		wr(TPC_OFF_SCS, {14'h0000, s});
		wr(TPC_OFF_OUTC, {14'h0000, o});
		wr(TPC_OFF_MODE, {13'h0000, m});
	endtask
	// Period and high time of the pin, rise to rise
	task automatic meas(output int p_n, output int h_n);
		logic p0, p;
		bit st;
		int j;
		p0 = 1'b1;
		st = 1'b0;
		p_n = 0;
		h_n = 0;
		for (j = 0; j < 5000; j++)
		begin
			@(negedge core_clk_in);
			p = pin;
			if (p === 1'b1 && p0 === 1'b0)
			begin
				if (st)
					break;
				st = 1'b1;
			end
			p_n += st;
			h_n += st && p === 1'b1;
			p0 = p;
		end
	endtask
	task automatic results();
		if (error_cnt == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Watchdog
	initial
	begin
		#300000;
		error_cnt++;
		results();
	end
	// =========================================
	// Main sequence
	// =========================================
	initial
	begin
		repeat (4) @(posedge core_clk_in);
		rst_in <= 1'b0;
		repeat (20) @(posedge core_clk_in);
		for (i = 0; i < 16; i++)
		begin
			rd(i[3:0], vd);
			`CHK(vd, 16'h0000)
		end
		for (i = 0; i < 7; i++)
		begin
			va = rnd();
			wr(i[3:0], va);
			rd(i[3:0], vd);
			`CHK(vd, va & msk[i])
			if (i == 0)
				wr(TPC_OFF_MODE, 16'h0000); // No random mode runs on random values
		end
		wr(TPC_OFF_MODE, 16'h0000);
		wr(TPC_OFF_CNT, 16'hFFFF);
		repeat (20) @(posedge core_clk_in);
		rd(TPC_OFF_CNT, vd);
		`CHK(vd, 16'h0000)
		// Edge codes in one-capture mode
		for (i = 0; i < 4; i++)
		begin
			cfg(TPC_M_CAP1, 3'h1, {2'h0, ecode[i]}, 2'h0, 2'h3);
			n_ca = 0;
			repeat (2) i_src.pulse(0, 20, 20);
			`CHK(n_ca, nexp[i])
		end
		// Glitches shorter than two samples
		cfg(TPC_M_CAP1, 3'h1, {2'h0, TPC_E_RISE}, 2'h0, 2'h3);
		n_ca = 0;
		i_src.pulse(0, 1, 20);
		`CHK(n_ca, 0)
		cfg(TPC_M_CAP1, 3'h1, {2'h0, TPC_E_RISE}, 2'h2, 2'h3);
		i_src.pulse(0, 3, 40);
		`CHK(n_ca, 0)
		i_src.pulse(0, 12, 40);
		`CHK(n_ca, 1)
		// Two inputs: offset between edges
		cfg(TPC_M_CAP2IN, 3'h1, {TPC_E_RISE, TPC_E_RISE}, 2'h0, 2'h3);
		n_cb = 0;
		k = 4 + rnd() % 20;
		fork
			i_src.pulse(0, 30, 10);
			begin
				repeat (k) @(posedge core_clk_in);
				i_src.pulse(1, 10, 10);
			end
		join
		rd(TPC_OFF_CCA, va);
		rd(TPC_OFF_CCB, vb);
		`CHK(va - vb, k[15:0])
		`CHK(n_cb, 1)
		// Two registers: pulse width
		k = 5 + rnd() % 30;
		cfg(TPC_M_CAP2REG, 3'h1, {2'h0, TPC_E_RISE}, 2'h0, 2'h3);
		i_src.pulse(0, k, 20);
		rd(TPC_OFF_CCA, va);
		rd(TPC_OFF_CCB, vb);
		`CHK(va - vb, k[15:0])
		// Both edges: no capture into A
		for (i = 5; i < 7; i++)
		begin
			cfg(i[2:0], 3'h1, {2'h0, TPC_E_BOTH}, 2'h0, 2'h3);
			vd = rnd();
			wr(TPC_OFF_CCA, vd);
			i_src.pulse(0, k, 20);
			rd(TPC_OFF_CCA, va);
			`CHK(va, vd)
		end
		// Restart measurement: period of rising edges
		k = 30 + rnd() % 50;
		cfg(TPC_M_RESTART, 3'h1, {2'h0, TPC_E_RISE}, 2'h0, 2'h3);
		repeat (3) i_src.pulse(0, 10, k);
		rd(TPC_OFF_CCB, vb);
		`CHK(vb >= k + 10 && vb <= k + 11, 1'b1)
		// Event counter
		vd = 3 + rnd() % 5;
		wr(TPC_OFF_CCA, vd);
		cfg(TPC_M_EVENT, 3'h0, {2'h0, TPC_E_RISE}, 2'h0, 2'h3);
		n_m = 0;
		for (i = 1; i <= vd; i++)
		begin
			i_src.pulse(0, 5, 5);
			rd(TPC_OFF_CNT, va);
			`CHK(va, i[15:0])
		end
		i_src.pulse(0, 5, 5);
		rd(TPC_OFF_CNT, va);
		`CHK(va, 16'h0000)
		`CHK(n_m, 1)
		// Pulse generator at two count clocks
		for (i = 1; i < 3; i++)
		begin
			va = 8 + rnd() % 32;
			vb = rnd() % va;
			wr(TPC_OFF_CCA, va);
			wr(TPC_OFF_CCB, vb);
			cfg(TPC_M_PPG, i[2:0], 4'h0, 2'h0, 2'h1);
			meas(per, hi);
			meas(per, hi);
			`CHK(per, int'(va + 1) << (i - 1))
			`CHK(hi, int'(vb + 1) << (i - 1))
		end
		// PWM, active low, over one sub-cycle
		vd = rnd();
		cfg(TPC_M_PWM, 3'h1, 4'h0, 2'h0, 2'h3);
		wr(TPC_OFF_CCA, {vd[13:0], 2'h0});
		repeat (16384) @(posedge core_clk_in);
		k = 0;
		repeat (16384)
		begin
			@(negedge core_clk_in);
			k += pin === 1'b0;
		end
		`CHK(k, int'(vd[13:0]))
		// Disable the pin while PWM keeps running; filtered levels idle low
		wr(TPC_OFF_OUTC, 16'h0000);
		repeat (20) @(posedge core_clk_in);
		rd(TPC_OFF_STAT, vd);
		`CHK(vd, 16'h0000)
		wr(TPC_OFF_MODE, 16'h0000);
		results();
	end
endmodule // timer_pwm_ppg_capture_modes_test

// ===== tb/tpc_pulse_src.sv
// Model of the external pulse sources on both trigger pins
module tpc_pulse_src
(
	input  wire logic core_clk_in, // Core clock
	output logic      trig_a_out,  // Source on trigger A
	output logic      trig_b_out   // Source on trigger B
);
	timeunit 1ns;
	timeprecision 100ps;
	// Both sources idle low
	initial
	begin
		trig_a_out = 1'b0;
		trig_b_out = 1'b0;
	end
	// One pulse: hi cycles high, then lo cycles low
	task automatic pulse(input bit sel_b, input int hi, input int lo);
		@(posedge core_clk_in);
		if (sel_b)
			trig_b_out <= 1'b1;
		else
			trig_a_out <= 1'b1;
		repeat (hi) @(posedge core_clk_in);
		if (sel_b)
			trig_b_out <= 1'b0;
		else
			trig_a_out <= 1'b0;
		repeat (lo) @(posedge core_clk_in);
	endtask
endmodule // tpc_pulse_src

// ===== tb/tpc_timer_asserts.sv
// Port-level checker for the timer block, bound into the timer
module tpc_timer_asserts
	import tpc_pkg::*;
(
	input wire logic              core_clk_in,
	input wire logic              rst_in,
	input wire logic [TPC_AW-1:0] reg_addr_in,
	input wire logic [TPC_DW-1:0] reg_wdata_in,
	input wire logic              reg_wr_in,
	input wire logic              reg_rd_in,
	input wire logic [TPC_DW-1:0] reg_rdata_out,
	input wire logic              trigger_input_a_in,
	input wire logic              trigger_input_b_in,
	input wire logic              timer_output_pin_out,
	input wire logic              capture_a_irq_out,
	input wire logic              capture_b_irq_out,
	input wire logic              match_irq_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// =========================================
	// Shadow of mode and output control
	// =========================================
	logic [2:0] mode_q; // Shadow mode
	logic       oe_q;   // Shadow enable
	logic       alv_q;  // Shadow level select
	logic [3:0] calm_q; // Cycles since a write
	logic [3:0] calm_d; // Next calm count
	wire wr_mode = reg_wr_in && reg_addr_in == TPC_OFF_MODE;
	wire wr_outc = reg_wr_in && reg_addr_in == TPC_OFF_OUTC;
	wire calm    = calm_q == 4'hF;
	wire cap_m   = mode_q >= TPC_M_CAP1 && mode_q <= TPC_M_RESTART;
	wire cnt_m   = mode_q == TPC_M_PPG || mode_q == TPC_M_EVENT;
	wire idle_m  = mode_q != TPC_M_PWM && mode_q != TPC_M_PPG;
	assign calm_d = reg_wr_in ? 4'h0 : calm_q + {3'h0, !calm};

	// Track writes; settle time hides edges still in flight
	always_ff @(posedge core_clk_in)
	begin
		mode_q <= rst_in ? 3'h0 : wr_mode ? reg_wdata_in[2:0] : mode_q;
		oe_q   <= rst_in ? 1'b0 : wr_outc ? reg_wdata_in[TPC_OE_BIT] : oe_q;
		alv_q  <= rst_in ? 1'b0 : wr_outc ? reg_wdata_in[TPC_ALV_BIT] : alv_q;
		calm_q <= rst_in ? 4'h0 : calm_d;
	end

	// =========================================
	// Properties
	// =========================================
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
		else $error("read data outside read cycle");
	stop_count_a: assert property ($past(reg_rd_in && reg_addr_in == TPC_OFF_CNT) && calm
		&& mode_q == TPC_M_STOP |-> reg_rdata_out == 16'h0000)
		else $error("count not zero in stop mode");
	irq_a_pulse_a: assert property (capture_a_irq_out |=> !capture_a_irq_out)
		else $error("capture A irq longer than one cycle");
	match_pulse_a: assert property (match_irq_out |-> ##1 !match_irq_out)
		else $error("match irq longer than one cycle");
	irq_a_mode_a: assert property (calm && !cap_m |-> !capture_a_irq_out)
		else $error("capture A irq outside capture modes");
	irq_b_mode_a: assert property (calm && mode_q != TPC_M_CAP2IN |-> !capture_b_irq_out)
		else $error("capture B irq outside two-input mode");
	match_mode_a: assert property (calm && !cnt_m |-> !match_irq_out)
		else $error("match irq in wrong mode");
	pin_off_a: assert property (calm && !oe_q |-> !timer_output_pin_out)
		else $error("pin driven while disabled");
	pin_idle_a: assert property (calm && oe_q && idle_m |-> timer_output_pin_out == alv_q)
		else $error("idle pin not at inactive level");
	cover property (capture_a_irq_out);
	cover property (capture_b_irq_out);
	cover property (match_irq_out);
endmodule // tpc_timer_asserts

bind tpc_timer tpc_timer_asserts i_asserts (
	.core_clk_in(core_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out), .trigger_input_a_in(trigger_input_a_in),
	.trigger_input_b_in(trigger_input_b_in), .timer_output_pin_out(timer_output_pin_out),
	.capture_a_irq_out(capture_a_irq_out), .capture_b_irq_out(capture_b_irq_out),
	.match_irq_out(match_irq_out));
